// ==== dos_clock_synth_map.vh ====
`ifndef DOS_CLOCK_SYNTH_MAP_VH
`define DOS_CLOCK_SYNTH_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DOS_OFS_FREQ 8'h00
`define DOS_OFS_RATIO 8'h04
`define DOS_OFS_MODE 8'h08
`define DOS_OFS_STATUS 8'h0C

// ****************************************
// Frequency register fields
// ****************************************
`define DOS_FREQ_WORD_LSB 0
`define DOS_FREQ_WORD_MSB 9
`define DOS_FREQ_RANGE_LSB 10
`define DOS_FREQ_RANGE_MSB 14

// ****************************************
// Mode register fields
// ****************************************
`define DOS_MODE_REF_CODE_LO 0
`define DOS_MODE_REF_CODE_HI 1
`define DOS_MODE_MAIN_CODE_LO 2
`define DOS_MODE_MAIN_CODE_HI 3
`define DOS_MODE_BYPASS 4
`define DOS_MODE_REF_GATE 5
`define DOS_MODE_REF_SOURCE 6
`define DOS_MODE_REF_SLEEP 7
`define DOS_MODE_MAIN_SLEEP 8

// ****************************************
// Status register fields
// ****************************************
`define DOS_STAT_LOW_POWER 0
`define DOS_STAT_REF_CTRL 1
`define DOS_STAT_MAIN_CTRL 2
`define DOS_STAT_REF_DRIVE 3
`define DOS_STAT_MAIN_DRIVE 4

// ****************************************
// Stored power-up settings
// ****************************************
`define DOS_RST_WORD 10'h01F4
`define DOS_RST_RANGE 5'h0C
`define DOS_RST_RATIO 10'h0000
`define DOS_RST_MODE 9'h010

// ****************************************
// Bus answers and prescale codes
// ****************************************
`define DOS_RESP_OKAY 2'h0
`define DOS_RESP_SLVERR 2'h2
`define DOS_PRE_RATIO_BYPASS 2'h0
`define DOS_PRE_DIV2 2'h1
`define DOS_PRE_DIV4 2'h2
`define DOS_PRE_DIV8 2'h3

`endif

// ==== dos_clock_synth_ctrl.v ====
// Function
// - Reference prescaler divides master by 1,2,4,8
// - Main prescaler divides master, feeds ratio stage
// - Ratio stage divides by two to 1025
// - Bypass bit routes main prescaler to pin
// - Range select and control word together tune master over two-to-one
// - Step size fixed per variant, three choices
// - Range select picks sub-range of master
// - Outputs enable synchronously, glitch free, once source level is low
// - Both outputs synchronous, independently programmed
// - Stored settings load as active at power-up
// - Host programs settings; device keeps them
// - Reference pin fed from reference select mux
// - Main frequency follows settings in cascade
// - Gate0 source1 sleep0: control pin selects mux
// - Gate1: control high floats, low drives source
// - Sleep1: control high stops master, floats pin
// - All bits zero: pin floats, high powers down
// - Main sleep0: main control is active-low enable
// - Main sleep1: high floats pin, powers down
// - Both sleep requests ORed into device power-down
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`include "dos_clock_synth_map.vh"

module dos_clock_synth_ctrl #(
  parameter ACC_WIDTH = 32,
  parameter [31:0] STEP_INC = 32'h0000_0D1B,
  parameter [31:0] RANGE_BASE = 32'h2000_0000,
  parameter [31:0] RANGE_STEP = 32'h0119_9999
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Control pins
  input wire refControlPin,
  input wire mainControlPin,
  // Clock pins
  output reg refClockPin,
  output reg refClockPinOeN,
  output reg mainClockPin,
  output reg mainClockPinOeN,
  // Power state
  output reg lowPower
);

  // ****************************************
  // Functions
  // ****************************************
  function [2:0] preMask;
    input [1:0] code;
    begin
      case (code)
        `DOS_PRE_RATIO_BYPASS: preMask = 3'h0;
        `DOS_PRE_DIV2: preMask = 3'h1;
        `DOS_PRE_DIV4: preMask = 3'h3;
        `DOS_PRE_DIV8: preMask = 3'h7;
        default: preMask = 3'h0;
      endcase
    end
  endfunction

  function isMapped;
    input [7:0] addr;
    begin
      isMapped = (addr == `DOS_OFS_FREQ) || (addr == `DOS_OFS_RATIO) ||
                 (addr == `DOS_OFS_MODE) || (addr == `DOS_OFS_STATUS);
    end
  endfunction

  // ****************************************
  // Settings
  // ****************************************
  reg [9:0] ctrlWord;
  reg [4:0] rangeSel;
  reg [9:0] ratioValue;
  reg [8:0] modeBits;
  wire [1:0] refCode = modeBits[`DOS_MODE_REF_CODE_HI:`DOS_MODE_REF_CODE_LO];
  wire [1:0] mainCode = modeBits[`DOS_MODE_MAIN_CODE_HI:`DOS_MODE_MAIN_CODE_LO];
  wire ratioBypass = modeBits[`DOS_MODE_BYPASS];
  wire refGateBit = modeBits[`DOS_MODE_REF_GATE];
  wire refSourceBit = modeBits[`DOS_MODE_REF_SOURCE];
  wire refSleepBit = modeBits[`DOS_MODE_REF_SLEEP];
  wire mainSleepBit = modeBits[`DOS_MODE_MAIN_SLEEP];

  // ****************************************
  // Bus slave
  // ****************************************
  reg [7:0] wrAddr;
  reg [31:0] wrData;
  reg [3:0] wrStrb;
  reg awGot;
  reg wGot;
  reg [31:0] next_rdata;
  wire [31:0] freqRead = {17'h0_0000, rangeSel, ctrlWord};
  wire [31:0] strbMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
  wire [31:0] freqNew = (freqRead & ~strbMask) | (wrData & strbMask);
  wire [31:0] ratioNew = ({22'h00_0000, ratioValue} & ~strbMask) | (wrData & strbMask);
  wire [31:0] modeNew = ({23'h00_0000, modeBits} & ~strbMask) | (wrData & strbMask);
  reg refCtrl;
  reg mainCtrl;
  reg refDrive;
  reg mainDrive;

  always @* begin
    case (s_axi_araddr)
      `DOS_OFS_FREQ: next_rdata = freqRead;
      `DOS_OFS_RATIO: next_rdata = {22'h00_0000, ratioValue};
      `DOS_OFS_MODE: next_rdata = {23'h00_0000, modeBits};
      `DOS_OFS_STATUS: next_rdata = {27'h000_0000, mainDrive, refDrive, mainCtrl, refCtrl,
                                     lowPower};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DOS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DOS_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      awGot <= 1'b0;
      wGot <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      ctrlWord <= `DOS_RST_WORD;
      rangeSel <= `DOS_RST_RANGE;
      ratioValue <= `DOS_RST_RATIO;
      modeBits <= `DOS_RST_MODE;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wrAddr <= s_axi_awaddr;
        awGot <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        wGot <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awGot && wGot && !s_axi_bvalid) begin
        case (wrAddr)
          `DOS_OFS_FREQ: begin
            ctrlWord <= freqNew[`DOS_FREQ_WORD_MSB:`DOS_FREQ_WORD_LSB];
            rangeSel <= freqNew[`DOS_FREQ_RANGE_MSB:`DOS_FREQ_RANGE_LSB];
          end
          `DOS_OFS_RATIO: ratioValue <= ratioNew[9:0];
          `DOS_OFS_MODE: modeBits <= modeNew[8:0];
          default: ;
        endcase
        s_axi_bresp <= isMapped(wrAddr) ? `DOS_RESP_OKAY : `DOS_RESP_SLVERR;
        s_axi_bvalid <= 1'b1;
        awGot <= 1'b0;
        wGot <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= isMapped(s_axi_araddr) ? `DOS_RESP_OKAY : `DOS_RESP_SLVERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control pin synchronisers
  // ****************************************
  reg [1:0] ctrlS1;
  reg [1:0] ctrlS2;
  reg [1:0] ctrlS3;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrlS1 <= 2'h0;
      ctrlS2 <= 2'h0;
      ctrlS3 <= 2'h0;
      refCtrl <= 1'b0;
      mainCtrl <= 1'b0;
    end else begin
      ctrlS1 <= {mainControlPin, refControlPin};
      ctrlS2 <= ctrlS1;
      ctrlS3 <= ctrlS2;
      if (ctrlS2[0] == ctrlS3[0]) begin
        refCtrl <= ctrlS3[0];
      end
      if (ctrlS2[1] == ctrlS3[1]) begin
        mainCtrl <= ctrlS3[1];
      end
    end
  end

  // ****************************************
  // Mode decode and power-down
  // ****************************************
  wire refAllZero = !refGateBit && !refSourceBit && !refSleepBit;
  wire next_lowPower = (refCtrl && (refSleepBit || refAllZero)) || (mainCtrl && mainSleepBit);
  wire refWantPre = (!refGateBit && refSourceBit && !refSleepBit) ? refCtrl : refSourceBit;
  // Gate and sleep float on high
  wire refWantDrive = !refAllZero && !(refCtrl && (refGateBit || refSleepBit)) &&
                      !next_lowPower;
  // Main sleep floats pin on high
  wire mainWantDrive = !mainCtrl && !next_lowPower;

  // ****************************************
  // Master clock generator
  // ****************************************
  reg [ACC_WIDTH-1:0] acc;
  reg mclkTick;
  reg mclkLvl;
  wire [31:0] incr = RANGE_BASE + RANGE_STEP * {27'h000_0000, rangeSel} +
                     STEP_INC * {22'h00_0000, ctrlWord};
  wire [ACC_WIDTH:0] accSum = {1'b0, acc} + {1'b0, incr[ACC_WIDTH-1:0]};

  always @(posedge core_clk) begin
    if (!rst_n) begin
      acc <= {ACC_WIDTH{1'b0}};
      mclkTick <= 1'b0;
      mclkLvl <= 1'b0;
      lowPower <= 1'b0;
    end else begin
      lowPower <= next_lowPower;
      if (next_lowPower) begin
        acc <= {ACC_WIDTH{1'b0}};
        mclkTick <= 1'b0;
        mclkLvl <= 1'b0;
      end else begin
        acc <= accSum[ACC_WIDTH-1:0];
        mclkTick <= accSum[ACC_WIDTH];
        if (accSum[ACC_WIDTH]) begin
          mclkLvl <= !mclkLvl;
        end
      end
    end
  end

  // ****************************************
  // Prescalers
  // ****************************************
  wire [1:0] preTick;
  wire [1:0] preLvl;
  wire [3:0] preCodes = {mainCode, refCode};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gPre
      reg [2:0] cnt;
      reg tick;
      reg lvl;
      always @(posedge core_clk) begin
        if (!rst_n || lowPower) begin
          cnt <= 3'h0;
          tick <= 1'b0;
          lvl <= 1'b0;
        end else begin
          tick <= 1'b0;
          if (mclkTick) begin
            if ((cnt & preMask(preCodes[2*gi+1:2*gi])) == preMask(preCodes[2*gi+1:2*gi])) begin
              cnt <= 3'h0;
              tick <= 1'b1;
              lvl <= !lvl;
            end else begin
              cnt <= cnt + 3'h1;
            end
          end
        end
      end
      assign preTick[gi] = tick;
      assign preLvl[gi] = lvl;
    end
  endgenerate

  // ****************************************
  // Ratio divider
  // ****************************************
  reg [10:0] divCnt;
  reg divLvl;
  reg divTick;
  wire [10:0] divLast = {1'b0, ratioValue} + 11'h001;

  always @(posedge core_clk) begin
    if (!rst_n || lowPower) begin
      divCnt <= 11'h000;
      divLvl <= 1'b0;
      divTick <= 1'b0;
    end else begin
      divTick <= 1'b0;
      if (preTick[1]) begin
        if (divCnt >= divLast) begin
          divCnt <= 11'h000;
          divLvl <= !divLvl;
          divTick <= 1'b1;
        end else begin
          divCnt <= divCnt + 11'h001;
        end
      end
    end
  end

  // ****************************************
  // Output gating
  // ****************************************
  reg refSelPre;
  reg refLvlQ;
  reg mainLvlQ;
  wire refSrcLvl = refSelPre ? preLvl[0] : mclkLvl;
  wire mainSrcLvl = ratioBypass ? preLvl[1] : divLvl;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      refSelPre <= 1'b0;
      refLvlQ <= 1'b0;
      mainLvlQ <= 1'b0;
      refDrive <= 1'b0;
      mainDrive <= 1'b0;
      refClockPin <= 1'b0;
      refClockPinOeN <= 1'b1;
      mainClockPin <= 1'b0;
      mainClockPinOeN <= 1'b1;
    end else begin
      if (!mclkLvl && !preLvl[0]) begin
        refSelPre <= refWantPre;
      end
      if (!refSrcLvl || next_lowPower) begin
        refDrive <= refWantDrive;
      end
      if (!mainSrcLvl || next_lowPower) begin
        mainDrive <= mainWantDrive;
      end
      // Level delayed to match drive, so the pin is low when enabled
      refLvlQ <= refSrcLvl;
      mainLvlQ <= mainSrcLvl;
      refClockPin <= refDrive & refLvlQ;
      refClockPinOeN <= !refDrive;
      mainClockPin <= mainDrive & mainLvlQ;
      mainClockPinOeN <= !mainDrive;
    end
  end

endmodule

// ==== dos_ctrl_checker.sv ====
// ****************************************
// Port checker
// ****************************************
module dos_ctrl_checker (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  // Pins
  input wire refControlPin,
  input wire mainControlPin,
  input wire refClockPin,
  input wire refClockPinOeN,
  input wire mainClockPin,
  input wire mainClockPinOeN,
  input wire lowPower
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_quiet;
    (!refControlPin && !mainControlPin) [*8];
  endsequence
  a_write_answer: assert property (
    s_wr_take |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer");
  a_read_answer: assert property (
    s_rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read answer");
  a_bad_read: assert property (
    s_rd_take ##0 (s_axi_araddr > 8'h0C) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read");
  a_ref_glitch: assert property (
    $fell(refClockPinOeN) |-> !refClockPin) else $error("ref enable glitch");
  a_main_glitch: assert property (
    $fell(mainClockPinOeN) |-> !mainClockPin) else $error("main enable glitch");
  a_float_quiet: assert property (
    (refClockPinOeN -> !refClockPin) && (mainClockPinOeN -> !mainClockPin)) else $error("float");
  a_sleep_floats: assert property (
    lowPower [*2] |-> refClockPinOeN && mainClockPinOeN) else $error("sleep drives");
  a_wake_quiet: assert property (
    s_quiet |=> !lowPower) else $error("sleep without request");
endmodule

// ==== dos_pin_model.sv ====
// ****************************************
// Pin side model
// ****************************************
module dos_pin_model (
  // Clock
  input wire core_clk,
  // Requests
  input wire refReq,
  input wire mainReq,
  // Device pins
  input wire refClockPin,
  input wire refClockPinOeN,
  input wire mainClockPin,
  input wire mainClockPinOeN,
  output logic refControlPin,
  output logic mainControlPin,
  output logic refLine = 1'b0,
  output logic mainLine = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  assign refControlPin = refReq;
  assign mainControlPin = mainReq;
  // Floating line toggles
  always @(posedge core_clk) begin
    refLine <= refClockPinOeN ? ~refLine : refClockPin;
    mainLine <= mainClockPinOeN ? ~mainLine : mainClockPin;
  end
endmodule

// ==== tb_dual_output_clock_synth_ctrl.sv ====
// ****************************************
// Bench
// ****************************************
module tb_dual_output_clock_synth_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [31:0] BASE = 32'h2000_0000;
  localparam [31:0] STEP_R = 32'h0119_9999;
  localparam [31:0] STEP_W = 32'h0000_0D1B;
  localparam int W = 12000;
  logic core_clk = 0, rst_n = 0, refReq = 0, mainReq = 0, counting = 0, refPrev, mainPrev;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d, v;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, pd, rdv, mdv;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire refControlPin, mainControlPin, refClockPin, refClockPinOeN;
  wire mainClockPin, mainClockPinOeN, lowPower, refLine, mainLine;
  int n_mismatch = 0, compares = 0, refEdges = 0, mainEdges = 0, i, k;
  dos_clock_synth_ctrl #(.ACC_WIDTH(32), .STEP_INC(STEP_W), .RANGE_BASE(BASE),
    .RANGE_STEP(STEP_R)) dut_u (.*);
  dos_pin_model pin_u (.*);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    refPrev <= refLine;
    mainPrev <= mainLine;
    if (counting && refLine && !refPrev) refEdges++;
    if (counting && mainLine && !mainPrev) mainEdges++;
  end
  task conclude;
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tmo;
    chk("timeout", 0, 1);
    conclude;
  endtask
  task wr(input [7:0] a, input [31:0] dt, input [3:0] s);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
    end
    if (n == 50) tmo;
  endtask
  task rd(input [7:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
    end
    if (n == 50) tmo;
  endtask
  function longint rate(input [9:0] w, input [4:0] rg);
    rate = (longint'(W) * (longint'(BASE) + longint'(STEP_R) * rg + longint'(STEP_W) * w)) >> 33;
  endfunction
  function int near(input int e, input int g);
    near = (g >= e - 2 && g <= e + 2) ? e : g;
  endfunction
  task win(input [9:0] w, input [4:0] rg, input [1:0] rc, input [1:0] mc, input byp,
    input [9:0] rat, input rsel);
    longint b;
    wr(8'h00, {17'h0, rg, w}, 4'hF);
    wr(8'h04, {22'h0, rat}, 4'hF);
    wr(8'h08, {27'h0_0000_02, byp, mc, rc}, 4'hF);
    refReq <= rsel;
    mainReq <= 0;
    repeat (64) @(posedge core_clk);
    refEdges = 0;
    mainEdges = 0;
    counting <= 1;
    repeat (W) @(posedge core_clk);
    counting <= 0;
    @(posedge core_clk);
    b = rate(w, rg);
    chk("refRate", b >> (rsel ? rc : 0), near(b >> (rsel ? rc : 0), refEdges));
    b = (b >> mc) / (byp ? 1 : rat + 2);
    chk("mainRate", b, near(b, mainEdges));
  endtask
  initial begin
    v = $urandom(32'h3c3b86da);
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    rd(8'h00);
    chk("freqReset", 32'h0000_31F4, d);
    rd(8'h04);
    chk("ratioReset", 32'h0000_0000, d);
    rd(8'h08);
    chk("modeReset", 32'h0000_0010, d);
    rd(8'h10);
    chk("badRead", 32'h0000_0002, {d, r});
    wr(8'h14, 32'hFFFF_FFFF, 4'hF);
    chk("badWrite", 2'h2, r);
    for (i = 0; i < 9; i++) begin
      v = $urandom;
      wr(8'(4 * (i % 3)), v, 4'hF);
      rd(8'(4 * (i % 3)));
      chk("readback", v & (i % 3 == 0 ? 32'h7FFF : i % 3 == 1 ? 32'h3FF : 32'h1FF), d);
    end
    wr(8'h00, 32'h0000_0000, 4'hF);
    wr(8'h00, 32'hFFFF_FFFF, 4'h2);
    rd(8'h00);
    chk("byteLane", 32'h0000_7F00, d);
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    rd(8'h00);
    chk("freqReload", 32'h0000_31F4, d);
    for (k = 0; k < 64; k++) begin
      wr(8'h08, {23'h0, k[3], k[2], k[1], k[0], 5'h10}, 4'hF);
      refReq <= k[4];
      mainReq <= k[5];
      repeat (40) @(posedge core_clk);
      pd = (k[4] && (k[2] || k[2:0] == 0)) || (k[5] && k[3]);
      rdv = !pd && (k[2:0] == 3'h2 ? 1'b1 : (k[0] || k[2]) ? !k[4] : 1'b0);
      mdv = !pd && !k[5];
      chk("refOeN", !rdv, refClockPinOeN);
      chk("mainOeN", !mdv, mainClockPinOeN);
      chk("lowPower", pd, lowPower);
      rd(8'h0C);
      chk("status", {27'h0, mdv, rdv, k[5], k[4], pd}, d);
    end
    for (i = 0; i < 4; i++) win($urandom, $urandom, i, 3 - i, 1, 0, 1);
    win($urandom, $urandom, 3, 0, 0, 0, 0);
    win($urandom, $urandom, 1, 1, 0, $urandom_range(20, 1), 1);
    conclude;
  end
endmodule
bind dos_clock_synth_ctrl dos_ctrl_checker chk_u (.*);
